/* rtl/tcu_capture_unit.sv */
// Capture unit top: APB registers, source select, prescaler and capture latch.
//
// Our own choices: the APB register port and the register offsets.
module tcu_capture_unit (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tcu_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cap_pin_i,
  input wire logic port_latch_i,
  input wire logic pin_direction_bit_i,
  input wire logic [2:0] cap_alt_i,
  input wire logic [15:0] first_odd_timer_i,
  input wire logic [15:0] second_odd_timer_i,
  input wire logic sleep_i,
  input wire logic timer_ext_clk_i,
  output logic capture_irq_flag_o,
  output logic capture_irq_enable_o,
  output logic capture_pulse_o
);

  localparam int NSRC = 4;

  function automatic logic is_capture(input logic [tcu_pkg::MODE_W-1:0] m);
    case (m)
      tcu_pkg::MODE_EDGE,
      tcu_pkg::MODE_FALL,
      tcu_pkg::MODE_RISE,
      tcu_pkg::MODE_DIV4,
      tcu_pkg::MODE_DIV16: is_capture = 1'b1;
      default: is_capture = 1'b0;
    endcase
  endfunction

  function automatic logic is_reg(input logic [tcu_pkg::ADDR_W-1:0] a);
    case (a)
      tcu_pkg::OFS_CTRL,
      tcu_pkg::OFS_CAPSEL,
      tcu_pkg::OFS_VAL_LO,
      tcu_pkg::OFS_VAL_HI,
      tcu_pkg::OFS_IRQ_FLAG,
      tcu_pkg::OFS_IRQ_EN,
      tcu_pkg::OFS_STATUS: is_reg = 1'b1;
      default: is_reg = 1'b0;
    endcase
  endfunction

  logic [7:0] module_control_reg_r;
  logic [7:0] capture_input_select_reg_r;
  logic [7:0] capture_value_low_r;
  logic [7:0] capture_value_high_r;
  logic capture_irq_flag_r;
  logic capture_irq_enable_r;
  logic [tcu_pkg::PSC_W-1:0] psc_cnt_r;
  logic [31:0] prdata_r;

  tcu_pkg::tcu_cfg_t cfg;
  tcu_pkg::tcu_evt_t evt;
  logic [NSRC-1:0] src_vec;
  logic pin_level;
  logic src_raw;
  logic active;
  logic run;
  logic cap_evt;
  logic [15:0] timebase_count;
  logic [15:0] capture_value_reg;
  logic setup;
  logic access;
  logic wr;
  logic wr_lane0;
  logic hit;
  logic [31:0] rd_word;

  assign cfg.en = module_control_reg_r[tcu_pkg::CTRL_EN_BIT];
  assign cfg.mode =
    module_control_reg_r[tcu_pkg::CTRL_MODE_LSB +: tcu_pkg::MODE_W];

  // An output-configured pin reads back the port latch, so a port write
  // that flips the level is seen as an edge.
  assign pin_level = pin_direction_bit_i ? cap_pin_i : port_latch_i;

  genvar gi;
  generate
    for (gi = 1; gi < NSRC; gi++)
    begin : g_alt
      assign src_vec[gi] = cap_alt_i[gi-1];
    end
  endgenerate
  assign src_vec[0] = pin_level;

  assign src_raw =
    src_vec[capture_input_select_reg_r[tcu_pkg::CAPSEL_SRC_LSB +: tcu_pkg::SRC_W]];

  tcu_edge_sync u_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .raw_i(src_raw),
    .evt_o(evt)
  );

  // Only odd timers are offered; select zero is the first one.
  assign timebase_count = capture_input_select_reg_r[tcu_pkg::CAPSEL_TMR_BIT]
    ? second_odd_timer_i : first_odd_timer_i;

  assign active = cfg.en & is_capture(cfg.mode);

  // Without an external timer clock the system clock stops in sleep, so
  // capture pauses with the timer and resumes where it left off.
  assign run = ~(sleep_i & ~timer_ext_clk_i);

  // The prescaled modes share one rising-edge counter, so a direct switch
  // keeps its count and may fire early; software clears the control first.
  always_comb
  begin
    cap_evt = 1'b0;
    case (cfg.mode)
      tcu_pkg::MODE_EDGE: cap_evt = evt.rise | evt.fall;
      tcu_pkg::MODE_FALL: cap_evt = evt.fall;
      tcu_pkg::MODE_RISE: cap_evt = evt.rise;
      tcu_pkg::MODE_DIV4:
        cap_evt = evt.rise &
          (psc_cnt_r[1:0] == tcu_pkg::DIV4_MASK);
      tcu_pkg::MODE_DIV16:
        cap_evt = evt.rise &
          (psc_cnt_r == tcu_pkg::DIV16_MASK);
      default: cap_evt = 1'b0;
    endcase
    cap_evt = cap_evt & active & run;
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      psc_cnt_r <= tcu_pkg::PSC_ZERO;
    end
    else if (!active)
    begin
      psc_cnt_r <= tcu_pkg::PSC_ZERO;
    end
    else if (evt.rise && run)
    begin
      psc_cnt_r <= psc_cnt_r + 4'h1;
    end
  end

  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign hit = is_reg(paddr);
  assign wr = access & pwrite & hit;
  assign wr_lane0 = wr & pstrb[0];

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      module_control_reg_r <= tcu_pkg::CTRL_RST;
    end
    else if (wr_lane0 && paddr == tcu_pkg::OFS_CTRL)
    begin
      module_control_reg_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      capture_input_select_reg_r <= tcu_pkg::CAPSEL_RST;
    end
    else if (wr_lane0 && paddr == tcu_pkg::OFS_CAPSEL)
    begin
      capture_input_select_reg_r <= pwdata[7:0];
    end
  end

  // A capture in the same cycle as a software write wins: the newest
  // event is kept, and an unread value is simply replaced.
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      capture_value_low_r <= tcu_pkg::BYTE_ZERO;
      capture_value_high_r <= tcu_pkg::BYTE_ZERO;
    end
    else if (cap_evt)
    begin
      capture_value_low_r <= timebase_count[7:0];
      capture_value_high_r <= timebase_count[15:8];
    end
    else if (wr_lane0)
    begin
      if (paddr == tcu_pkg::OFS_VAL_LO)
      begin
        capture_value_low_r <= pwdata[7:0];
      end
      if (paddr == tcu_pkg::OFS_VAL_HI)
      begin
        capture_value_high_r <= pwdata[7:0];
      end
    end
  end

  assign capture_value_reg = {capture_value_high_r, capture_value_low_r};

  // Writing zero clears the flag; a capture in that same cycle sets it,
  // and nothing in hardware ever clears it.
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      capture_irq_flag_r <= 1'b0;
    end
    else if (cap_evt)
    begin
      capture_irq_flag_r <= 1'b1;
    end
    else if (wr_lane0 && paddr == tcu_pkg::OFS_IRQ_FLAG)
    begin
      capture_irq_flag_r <= pwdata[tcu_pkg::FLAG_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      capture_irq_enable_r <= 1'b0;
    end
    else if (wr_lane0 && paddr == tcu_pkg::OFS_IRQ_EN)
    begin
      capture_irq_enable_r <= pwdata[tcu_pkg::FLAG_BIT];
    end
  end

  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (paddr)
      tcu_pkg::OFS_CTRL: rd_word[7:0] = module_control_reg_r;
      tcu_pkg::OFS_CAPSEL: rd_word[7:0] = capture_input_select_reg_r;
      tcu_pkg::OFS_VAL_LO: rd_word[7:0] = capture_value_reg[7:0];
      tcu_pkg::OFS_VAL_HI: rd_word[7:0] = capture_value_reg[15:8];
      tcu_pkg::OFS_IRQ_FLAG: rd_word[tcu_pkg::FLAG_BIT] = capture_irq_flag_r;
      tcu_pkg::OFS_IRQ_EN: rd_word[tcu_pkg::FLAG_BIT] = capture_irq_enable_r;
      tcu_pkg::OFS_STATUS:
      begin
        rd_word[tcu_pkg::STAT_LVL_BIT] = evt.level;
        rd_word[tcu_pkg::STAT_CNT_LSB +: tcu_pkg::PSC_W] = psc_cnt_r;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Read data is taken in the setup cycle so it leaves a flip-flop; the
  // cost is that a capture during the access phase shows only next read.
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      prdata_r <= 32'h0000_0000;
    end
    else if (setup && !pwrite)
    begin
      prdata_r <= rd_word;
    end
  end

  assign prdata = prdata_r;
  assign pready = access;
  assign pslverr = access & ~hit;

  assign capture_irq_flag_o = capture_irq_flag_r;
  assign capture_irq_enable_o = capture_irq_enable_r;
  assign capture_pulse_o = cap_evt;

endmodule

/* rtl/tcu_edge_sync.sv */
// Two-stage synchroniser with rise and fall detection for the capture input.
module tcu_edge_sync (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic raw_i,
  output tcu_pkg::tcu_evt_t evt_o
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  // The first stage feeds only the second; edges are judged one stage later.
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end
    else
    begin
      meta_r <= raw_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // Each edge appears for exactly one cycle, so it can only be counted once.
  always_comb
  begin
    evt_o.level = sync_r;
    evt_o.rise = sync_r & ~prev_r;
    evt_o.fall = ~sync_r & prev_r;
  end

endmodule

/* rtl/tcu_pkg.sv */
// Package with register map, field layout, modes and carrier types of the capture unit.
// Behaviour
// - On a qualifying event, copy the whole 16-bit timer count into the capture value.
// - Mode selects falling, rising, every 4th rising, every 16th rising or every edge.
// - Every capture sets the capture flag, which stays set until cleared.
// - A new capture overwrites an unread value; there is no overrun protection.
// - The capture value is two separately accessible 8-bit registers, low and high.
// - Prescale counter clears when module off, not capturing, or on reset.
// - Switching directly between prescale settings keeps the counter; false capture possible.
// - A mode change may raise a false capture flag; it is not suppressed.
// - With the pin as output, a port write changing its level can trigger capture.
// - Capture uses odd timers only, first odd timer by default; timers may be shared.
// - With instruction clock, the timer holds during sleep and resumes after wake-up.
// - With an external timer clock, capture keeps working during sleep.
package tcu_pkg;

  localparam int ADDR_W = 12;

  localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_CAPSEL = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_VAL_LO = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_VAL_HI = 12'h00c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_FLAG = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h018;

  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_MODE_LSB = 0;
  localparam int MODE_W = 4;
  localparam int CAPSEL_SRC_LSB = 0;
  localparam int SRC_W = 2;
  localparam int CAPSEL_TMR_BIT = 4;
  localparam int FLAG_BIT = 0;
  localparam int STAT_LVL_BIT = 0;
  localparam int STAT_CNT_LSB = 4;
  localparam int PSC_W = 4;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CAPSEL_RST = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [PSC_W-1:0] PSC_ZERO = 4'h0;
  localparam logic [1:0] DIV4_MASK = 2'h3;
  localparam logic [PSC_W-1:0] DIV16_MASK = 4'hf;

  typedef enum logic [MODE_W-1:0] {
    MODE_OFF = 4'h0,
    MODE_EDGE = 4'h3,
    MODE_FALL = 4'h4,
    MODE_RISE = 4'h5,
    MODE_DIV4 = 4'h6,
    MODE_DIV16 = 4'h7
  } tcu_mode_t;

  typedef struct packed {
    logic en;
    logic [MODE_W-1:0] mode;
  } tcu_cfg_t;

  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } tcu_evt_t;

endpackage

/* verif/tb.sv */
// Self-checking testbench for the capture unit.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_b_i = 0, psel = 0, penable = 0, pwrite = 0, err, pin, busy, go = 0;
  logic latch = 0, slp = 0, ext = 0, flag, ien, pulse, pready, pslverr;
  logic dir = 1;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic [1:0] src = 0;
  logic [4:0] n = 0;
  logic [15:0] t1 = 0, t2 = 0;
  int fails = 0, compares = 0, caps = 0;
  logic [3:0] rm [6] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h3, 4'h5};
  logic [7:0] rc [6] = '{8'h00, 8'h01, 8'h00, 8'h10, 8'h03, 8'h12};
  logic [4:0] rn [6] = '{5'd3, 5'd3, 5'd8, 5'd16, 5'd2, 5'd2};
  int rk [6] = '{3, 3, 2, 1, 4, 2};
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (pulse === 1'b1) caps++;
  tcu_capture_unit tcu_capture_unit_i (.clk_i, .rst_b_i, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr, .cap_pin_i(src == 2'd0 && pin),
    .port_latch_i(latch), .pin_direction_bit_i(dir), .cap_alt_i({3{pin}} & 3'(4'h1 << src >> 1)),
    .first_odd_timer_i(t1), .second_odd_timer_i(t2), .sleep_i(slp), .timer_ext_clk_i(ext),
    .capture_irq_flag_o(flag), .capture_irq_enable_o(ien), .capture_pulse_o(pulse));
  tcu_src_model tcu_src_model_i (.clk_i, .rst_b_i, .go_i(go), .n_i(n), .pin_o(pin), .busy_o(busy));
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("Counts: %0d compares, %0d fails", compares, fails);
    if (fails == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int k;
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_i);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20)
    begin
      fails++;
      final_report();
    end
  endtask
  // The source frame ends, then four edges let the synchroniser and latch settle.
  task automatic fire(input logic [4:0] c);
    int k;
    n <= c;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (busy !== 1'b0 && k < 400);
    repeat (4) @(posedge clk_i);
    if (k >= 400)
    begin
      fails++;
      final_report();
    end
  endtask
  task automatic cfg(input logic [7:0] c, input logic [7:0] s);
    src <= s[1:0];
    apb(1, tcu_pkg::OFS_CTRL, 8'h00);
    apb(1, tcu_pkg::OFS_CAPSEL, s);
    apb(1, tcu_pkg::OFS_CTRL, c);
    apb(1, tcu_pkg::OFS_IRQ_FLAG, 8'h00);
    caps = 0;
  endtask
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    apb(0, tcu_pkg::OFS_CTRL, 8'h00);
    chk("ctrl reset", q, 32'h0);
    chk("flag reset", flag, 32'h0);
    $display("reset test done");
    for (int i = 0; i < 6; i++)
    begin
      t1 <= 16'h12a0 + 16'(i);
      t2 <= 16'hbe05 - 16'(i);
      cfg({4'h8, rm[i]}, rc[i]);
      fire(rn[i]);
      chk("captures", caps, rk[i]);
      chk("flag", flag, 32'h1);
      apb(0, tcu_pkg::OFS_VAL_LO, 8'h00);
      chk("low byte", q, rc[i][4] ? t2[7:0] : t1[7:0]);
      apb(0, tcu_pkg::OFS_VAL_HI, 8'h00);
      chk("high byte", q, rc[i][4] ? t2[15:8] : t1[15:8]);
      $display("row %0d done", i);
    end
    cfg(8'h87, 8'h00);
    fire(5);
    apb(1, tcu_pkg::OFS_CTRL, 8'h85);
    apb(0, tcu_pkg::OFS_STATUS, 8'h00);
    chk("prescale kept", q, 32'h50);
    apb(1, tcu_pkg::OFS_CTRL, 8'h00);
    apb(0, tcu_pkg::OFS_STATUS, 8'h00);
    chk("prescale off", q, 32'h0);
    cfg(8'h85, 8'h00);
    dir <= 1'b0;
    latch <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk("port write", caps, 1);
    latch <= 1'b0;
    dir <= 1'b1;
    slp <= 1'b1;
    cfg(8'h85, 8'h00);
    fire(1);
    chk("asleep", caps, 0);
    ext <= 1'b1;
    fire(1);
    chk("asleep ext", caps, 1);
    slp <= 1'b0;
    ext <= 1'b0;
    repeat (9) @(posedge clk_i);
    chk("flag held", flag, 32'h1);
    apb(1, tcu_pkg::OFS_IRQ_FLAG, 8'h00);
    // The write lands at the edge the task returns on; look once it has settled.
    @(posedge clk_i);
    chk("flag cleared", flag, 32'h0);
    apb(1, tcu_pkg::OFS_IRQ_EN, 8'h01);
    @(posedge clk_i);
    chk("enable", ien, 32'h1);
    apb(1, tcu_pkg::OFS_IRQ_EN, 8'h00);
    apb(0, 12'h020, 8'h00);
    chk("unmapped data", q, 32'h0);
    chk("unmapped err", err, 32'h1);
    cfg(8'h87, 8'h00);
    fire(3);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    apb(0, tcu_pkg::OFS_STATUS, 8'h00);
    chk("prescale reset", q, 32'h0);
    $display("hand tests done");
    final_report();
  end
endmodule

/* verif/tcu_checker.sv */
// Port-level assertions for the capture unit, bound to its top module.
module tcu_checker (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tcu_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sleep_i,
  input wire logic timer_ext_clk_i,
  input wire logic capture_irq_flag_o,
  input wire logic capture_irq_enable_o,
  input wire logic capture_pulse_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic acc;
  logic fwr;
  assign acc = psel && penable;
  assign fwr = acc && pwrite && paddr == tcu_pkg::OFS_IRQ_FLAG;
  a_ready_now: assert property (acc |-> pready)
    else $error("pready missing in access phase");
  a_unmapped_err: assert property (
    acc && !pwrite && paddr > tcu_pkg::OFS_STATUS |-> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  a_byte_wide: assert property (
    acc && !pwrite && paddr[11:3] == 9'h001 |-> prdata[31:8] == 24'h0)
    else $error("capture byte wider than eight bits");
  a_capture_flags: assert property (capture_pulse_o |=> capture_irq_flag_o)
    else $error("capture did not set flag");
  a_flag_cause: assert property (
    $rose(capture_irq_flag_o) |-> $past(capture_pulse_o) || $past(fwr))
    else $error("flag set without cause");
  a_flag_sw_clear: assert property (
    $fell(capture_irq_flag_o) |-> $past(fwr) && !$past(pwdata[0]))
    else $error("flag cleared by hardware");
  a_sleep_hold: assert property (sleep_i && !timer_ext_clk_i |-> !capture_pulse_o)
    else $error("capture while asleep on internal clock");
  a_enable_write: assert property (
    acc && pwrite && paddr == tcu_pkg::OFS_IRQ_EN |=> capture_irq_enable_o == $past(pwdata[0]))
    else $error("enable bit not stored");
  c_capture: cover property (capture_pulse_o);
  c_clear: cover property ($fell(capture_irq_flag_o));
  c_refuse: cover property (pslverr);
endmodule

bind tcu_capture_unit tcu_checker tcu_checker_i (.clk_i, .rst_b_i, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sleep_i, .timer_ext_clk_i,
  .capture_irq_flag_o, .capture_irq_enable_o, .capture_pulse_o);

/* verif/tcu_src_model.sv */
// External event source that toggles the capture input in frames of pulses.
module tcu_src_model (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic go_i,
  input wire logic [4:0] n_i,
  output logic pin_o,
  output logic busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] left_r;
  logic [1:0] ph_r;
  assign busy_o = left_r != 6'h0;
  // Edges stay four cycles apart, so the synchroniser sees each one separately.
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      left_r <= 6'h0;
      ph_r <= 2'h0;
      pin_o <= 1'b0;
    end
    else if (go_i)
    begin
      left_r <= {n_i, 1'b0};
      ph_r <= 2'h0;
    end
    else if (busy_o)
    begin
      ph_r <= ph_r + 2'h1;
      if (ph_r == 2'h3)
      begin
        pin_o <= ~pin_o;
        left_r <= left_r - 6'h1;
      end
    end
  end
endmodule
